// file: converter_fault_protection.sv
// Fault protection of a synchronous buck controller: comparator sync,
// fault flags, gate-drive gating, interrupt and APB register file.
// Assumes PWM inputs come from logic on clk; comparators are asynchronous.
// Function
// - Input undervoltage flag sets below lockout level
// - Input undervoltage flag clears itself on recovery
// - Flags set regardless of interrupt enables
// - Overcurrent events only when overcurrent enabled
// - Overcurrent sampled during high side, after blanking
// - Output undervoltage flag sets when monitor enabled
// - Undervoltage kill forces both drives low
// - Overvoltage monitoring only when enabled
// - Output overvoltage flag sets above threshold
// - Overvoltage kill forces both drives low
// - Overtemperature shuts switching down in hardware
// - Code protect refuses external program access
// - Seven-bit alert address register
// - Global driver disable forces both drives low
// - Side disable forces that drive low
`timescale 1ns/1ps
module converter_fault_protection
    import fault_prot_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vin_below_cmp,
    input wire logic overcurrent_cmp,
    input wire logic output_below_cmp,
    input wire logic output_above_cmp,
    input wire logic overtemp_cmp,
    input wire logic high_pwm,
    input wire logic low_pwm,
    output logic high_gate_drive,
    output logic low_gate_drive,
    output logic [7:0] input_lockout_level,
    output logic [7:0] output_uv_threshold,
    output logic [7:0] output_ov_threshold,
    output logic [6:0] alert_address,
    input wire logic prog_read_req,
    input wire logic prog_write_req,
    output logic prog_read_allow,
    output logic prog_write_allow,
    output logic irq
);

    // The decoder needs six address bits to reach the last register
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be between 6 and 32");
    end

    typedef struct packed {
        logic [NUM_FLAGS-1:0] sy1;
        logic [NUM_FLAGS-1:0] sy2;
        logic [NUM_FLAGS-1:0] sy3;
        logic [NUM_FLAGS-1:0] filt;
        logic [7:0] lockout;
        logic oc_en;
        logic [1:0] blank_sel;
        logic uv_mon;
        logic ov_mon;
        logic [7:0] uv_thr;
        logic [7:0] ov_thr;
        logic uv_kill;
        logic ov_kill;
        logic drv_dis;
        logic hi_dis;
        logic lo_dis;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] mask;
        logic global_irq_enable;
        logic [6:0] alert;
        logic cp;
        logic [7:0] blank_cnt;
        logic hi_drv;
        logic lo_drv;
        logic [31:0] rdata;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    logic [7:0] reg_addr;
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [7:0] blank_lim;
    logic blank_done;
    logic oc_event;
    logic [NUM_FLAGS-1:0] set_ev;
    logic [NUM_FLAGS-1:0] clr_w1c;
    logic drive_kill;
    logic [31:0] rd_mux;

    assign reg_addr = 8'(paddr);
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;

    always_comb begin
        unique case (reg_addr)
            OFS_INPUT_LOCKOUT_LEVEL, OFS_OVERCURRENT_CONTROL, OFS_ANALOG_BLOCK_ENABLES,
            OFS_OUTPUT_UV_THRESHOLD, OFS_OUTPUT_OV_THRESHOLD, OFS_PROTECTION_ENABLES,
            OFS_ANALOG_TEST_CONTROL, OFS_PERIPHERAL_FLAGS_TWO, OFS_IRQ_MASK,
            OFS_INTERRUPT_CONTROL, OFS_ALERT_ADDRESS, OFS_CODE_PROTECT: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_hit;

    always_comb begin
        rd_mux = 32'h0;
        unique case (reg_addr)
            OFS_INPUT_LOCKOUT_LEVEL: rd_mux[7:0] = state_ff.lockout;
            OFS_OVERCURRENT_CONTROL: rd_mux[2:0] = {state_ff.blank_sel, state_ff.oc_en};
            OFS_ANALOG_BLOCK_ENABLES: rd_mux[1:0] = {state_ff.ov_mon, state_ff.uv_mon};
            OFS_OUTPUT_UV_THRESHOLD: rd_mux[7:0] = state_ff.uv_thr;
            OFS_OUTPUT_OV_THRESHOLD: rd_mux[7:0] = state_ff.ov_thr;
            OFS_PROTECTION_ENABLES: rd_mux[1:0] = {state_ff.ov_kill, state_ff.uv_kill};
            OFS_ANALOG_TEST_CONTROL:
                rd_mux[2:0] = {state_ff.lo_dis, state_ff.hi_dis, state_ff.drv_dis};
            OFS_PERIPHERAL_FLAGS_TWO: rd_mux[NUM_FLAGS-1:0] = state_ff.flags;
            OFS_IRQ_MASK: rd_mux[NUM_FLAGS-1:0] = state_ff.mask;
            OFS_INTERRUPT_CONTROL: rd_mux[0] = state_ff.global_irq_enable;
            OFS_ALERT_ADDRESS: rd_mux[6:0] = state_ff.alert;
            OFS_CODE_PROTECT: rd_mux[0] = state_ff.cp;
            default: rd_mux = 32'h0;
        endcase
    end

    // Blanking restarts on every high-side on time
    always_comb begin
        unique case (state_ff.blank_sel)
            2'h0: blank_lim = BLANK0_CYC;
            2'h1: blank_lim = BLANK1_CYC;
            2'h2: blank_lim = BLANK2_CYC;
            2'h3: blank_lim = BLANK3_CYC;
        endcase
    end
    // Compare by magnitude so a shorter select chosen mid-pulse cannot skip the limit
    assign blank_done = high_pwm & (state_ff.blank_cnt >= blank_lim);
    assign oc_event = state_ff.oc_en & blank_done & state_ff.filt[FLAG_OC];

    // Sticky events; the input undervoltage bit is a live level instead
    assign set_ev[FLAG_VIN] = 1'b0;
    assign set_ev[FLAG_OC] = oc_event;
    assign set_ev[FLAG_OUV] = state_ff.uv_mon & state_ff.filt[FLAG_OUV];
    assign set_ev[FLAG_OOV] = state_ff.ov_mon & state_ff.filt[FLAG_OOV];
    assign set_ev[FLAG_OT] = state_ff.filt[FLAG_OT];

    assign clr_w1c = (wr_en && reg_addr == OFS_PERIPHERAL_FLAGS_TWO && pstrb[0]) ?
                     pwdata[NUM_FLAGS-1:0] : '0;

    assign drive_kill = state_ff.drv_dis
                      | state_ff.filt[FLAG_OT]
                      | (state_ff.uv_kill & state_ff.flags[FLAG_OUV])
                      | (state_ff.ov_kill & state_ff.flags[FLAG_OOV]);

    always_comb begin
        nxt_state = state_ff;
        // Only the second stage reads the first one
        nxt_state.sy1 = {overtemp_cmp, output_above_cmp, output_below_cmp,
                         overcurrent_cmp, vin_below_cmp};
        nxt_state.sy2 = state_ff.sy1;
        nxt_state.sy3 = state_ff.sy2;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            if (state_ff.sy2[i] == state_ff.sy3[i]) begin
                nxt_state.filt[i] = state_ff.sy2[i];
            end
        end

        if (!high_pwm) begin
            nxt_state.blank_cnt = 8'h0;
        end else if (state_ff.blank_cnt < blank_lim) begin
            nxt_state.blank_cnt = state_ff.blank_cnt + 8'h1;
        end

        // Set wins over a clear in the same cycle
        nxt_state.flags = (state_ff.flags & ~clr_w1c) | set_ev;
        nxt_state.flags[FLAG_VIN] = state_ff.filt[FLAG_VIN];

        nxt_state.hi_drv = high_pwm & ~drive_kill & ~state_ff.hi_dis;
        nxt_state.lo_drv = low_pwm & ~drive_kill & ~state_ff.lo_dis;

        if (rd_setup) begin
            nxt_state.rdata = rd_mux;
        end

        if (wr_en && pstrb[0]) begin
            unique case (reg_addr)
                OFS_INPUT_LOCKOUT_LEVEL: nxt_state.lockout = pwdata[7:0];
                OFS_OVERCURRENT_CONTROL: begin
                    nxt_state.oc_en = pwdata[OC_EN_BIT];
                    nxt_state.blank_sel = pwdata[OC_BLANK_LSB +: 2];
                end
                OFS_ANALOG_BLOCK_ENABLES: begin
                    nxt_state.uv_mon = pwdata[UV_MON_BIT];
                    nxt_state.ov_mon = pwdata[OV_MON_BIT];
                end
                OFS_OUTPUT_UV_THRESHOLD: nxt_state.uv_thr = pwdata[7:0];
                OFS_OUTPUT_OV_THRESHOLD: nxt_state.ov_thr = pwdata[7:0];
                OFS_PROTECTION_ENABLES: begin
                    nxt_state.uv_kill = pwdata[UV_KILL_BIT];
                    nxt_state.ov_kill = pwdata[OV_KILL_BIT];
                end
                OFS_ANALOG_TEST_CONTROL: begin
                    nxt_state.drv_dis = pwdata[DRV_DIS_BIT];
                    nxt_state.hi_dis = pwdata[HI_DIS_BIT];
                    nxt_state.lo_dis = pwdata[LO_DIS_BIT];
                end
                OFS_IRQ_MASK: nxt_state.mask = pwdata[NUM_FLAGS-1:0];
                OFS_INTERRUPT_CONTROL: nxt_state.global_irq_enable = pwdata[GIE_BIT];
                OFS_ALERT_ADDRESS: nxt_state.alert = pwdata[6:0];
                // Protection can be raised but only a reset lowers it
                OFS_CODE_PROTECT: nxt_state.cp = state_ff.cp | pwdata[CP_BIT];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= '0;
            state_ff.lockout <= LOCKOUT_LEVEL_RST;
            state_ff.blank_sel <= BLANK_SEL_RST;
            state_ff.uv_thr <= UV_THRESHOLD_RST;
            state_ff.ov_thr <= OV_THRESHOLD_RST;
            state_ff.alert <= ALERT_ADDRESS_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign prdata = state_ff.rdata;
    assign high_gate_drive = state_ff.hi_drv;
    assign low_gate_drive = state_ff.lo_drv;
    assign input_lockout_level = state_ff.lockout;
    assign output_uv_threshold = state_ff.uv_thr;
    assign output_ov_threshold = state_ff.ov_thr;
    assign alert_address = state_ff.alert;
    assign prog_read_allow = prog_read_req & ~state_ff.cp;
    assign prog_write_allow = prog_write_req & ~state_ff.cp;
    // Enables gate only the interrupt line, never the flags
    assign irq = state_ff.global_irq_enable & |(state_ff.flags & state_ff.mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_uvlo_sets: assert property (state_ff.filt[FLAG_VIN] |=> state_ff.flags[FLAG_VIN])
        else $error("input undervoltage flag did not follow comparator");
    a_uvlo_clears: assert property (!state_ff.filt[FLAG_VIN] |=> !state_ff.flags[FLAG_VIN])
        else $error("input undervoltage flag did not clear");
    a_flag_no_mask: assert property ((state_ff.uv_mon && state_ff.filt[FLAG_OUV]
        && !state_ff.mask[FLAG_OUV] && !state_ff.global_irq_enable) |=> state_ff.flags[FLAG_OUV])
        else $error("flag held back by interrupt enables");
    a_oc_disabled: assert property ((!state_ff.oc_en && !state_ff.flags[FLAG_OC])
        |=> !state_ff.flags[FLAG_OC])
        else $error("overcurrent flagged while disabled");
    a_oc_blanked: assert property ((!blank_done && !state_ff.flags[FLAG_OC])
        |=> !state_ff.flags[FLAG_OC])
        else $error("overcurrent flagged inside blanking");
    a_uv_sticky: assert property ((state_ff.flags[FLAG_OUV] && !clr_w1c[FLAG_OUV])
        |=> state_ff.flags[FLAG_OUV])
        else $error("output undervoltage flag dropped without clear");
    a_uv_kill: assert property ((state_ff.uv_kill && state_ff.flags[FLAG_OUV])
        |=> !high_gate_drive && !low_gate_drive)
        else $error("drive active with undervoltage kill");
    a_ov_gated: assert property ((!state_ff.ov_mon && !state_ff.flags[FLAG_OOV])
        |=> !state_ff.flags[FLAG_OOV])
        else $error("overvoltage flagged while monitor off");
    a_ov_kill: assert property ((state_ff.ov_kill && state_ff.flags[FLAG_OOV])
        |=> !high_gate_drive && !low_gate_drive)
        else $error("drive active with overvoltage kill");
    a_ot_shutdown: assert property (state_ff.filt[FLAG_OT]
        |=> !high_gate_drive && !low_gate_drive)
        else $error("drive active in overtemperature");
    a_cp_refuse: assert property (state_ff.cp |-> !prog_read_allow && !prog_write_allow)
        else $error("program access granted under code protect");
    a_global_off: assert property (state_ff.drv_dis |=> !high_gate_drive && !low_gate_drive)
        else $error("drive active while globally disabled");
    a_side_off: assert property ((state_ff.hi_dis && !drive_kill && !state_ff.lo_dis)
        |=> !high_gate_drive && (low_gate_drive == $past(low_pwm)))
        else $error("side disable wrong");
    a_sync_lag: assert property ($rose(state_ff.filt[FLAG_OC])
        |-> $past(state_ff.sy3[FLAG_OC]) && $past(state_ff.sy2[FLAG_OC]))
        else $error("comparator passed without synchroniser agreement");
    a_set_wins: assert property ((set_ev[FLAG_OOV] && clr_w1c[FLAG_OOV])
        |=> state_ff.flags[FLAG_OOV])
        else $error("clear beat a simultaneous set");

    c_oc_event: cover property (oc_event);
    c_uv_kill: cover property (state_ff.uv_kill && state_ff.flags[FLAG_OUV] ##1 !high_gate_drive);
    c_irq: cover property ($rose(irq));
    c_clear_set: cover property (set_ev[FLAG_OC] && clr_w1c[FLAG_OC]);

endmodule

// file: fault_prot_pkg.sv
// Constants shared by the converter fault-protection block.
// Assumes a 250 MHz core clock and a 32-bit APB register bus.
package fault_prot_pkg;

    localparam int CLK_PERIOD_PS = 4000;

    // Byte offsets of the register words
    localparam logic [7:0] OFS_INPUT_LOCKOUT_LEVEL = 8'h00;
    localparam logic [7:0] OFS_OVERCURRENT_CONTROL = 8'h04;
    localparam logic [7:0] OFS_ANALOG_BLOCK_ENABLES = 8'h08;
    localparam logic [7:0] OFS_OUTPUT_UV_THRESHOLD = 8'h0c;
    localparam logic [7:0] OFS_OUTPUT_OV_THRESHOLD = 8'h10;
    localparam logic [7:0] OFS_PROTECTION_ENABLES = 8'h14;
    localparam logic [7:0] OFS_ANALOG_TEST_CONTROL = 8'h18;
    localparam logic [7:0] OFS_PERIPHERAL_FLAGS_TWO = 8'h1c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_INTERRUPT_CONTROL = 8'h24;
    localparam logic [7:0] OFS_ALERT_ADDRESS = 8'h28;
    localparam logic [7:0] OFS_CODE_PROTECT = 8'h2c;

    // Flag positions, shared by status, mask and comparator vector
    localparam int NUM_FLAGS = 5;
    localparam int FLAG_VIN = 0;
    localparam int FLAG_OC = 1;
    localparam int FLAG_OUV = 2;
    localparam int FLAG_OOV = 3;
    localparam int FLAG_OT = 4;

    // Field positions
    localparam int OC_EN_BIT = 0;
    localparam int OC_BLANK_LSB = 1;
    localparam int UV_MON_BIT = 0;
    localparam int OV_MON_BIT = 1;
    localparam int UV_KILL_BIT = 0;
    localparam int OV_KILL_BIT = 1;
    localparam int DRV_DIS_BIT = 0;
    localparam int HI_DIS_BIT = 1;
    localparam int LO_DIS_BIT = 2;
    localparam int GIE_BIT = 0;
    localparam int CP_BIT = 0;

    // Values after reset
    localparam logic [7:0] LOCKOUT_LEVEL_RST = 8'h00;
    localparam logic [7:0] UV_THRESHOLD_RST = 8'h00;
    localparam logic [7:0] OV_THRESHOLD_RST = 8'hff;
    localparam logic [1:0] BLANK_SEL_RST = 2'h0;
    localparam logic [6:0] ALERT_ADDRESS_RST = 7'h0c;

    // Leading-edge blanking per select code, in ns
    localparam int BLANK0_NS = 114;
    localparam int BLANK1_NS = 336;
    localparam int BLANK2_NS = 558;
    localparam int BLANK3_NS = 780;
    localparam logic [7:0] BLANK0_CYC = 8'((BLANK0_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] BLANK1_CYC = 8'((BLANK1_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] BLANK2_CYC = 8'((BLANK2_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] BLANK3_CYC = 8'((BLANK3_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

endpackage

// file: testbench.sv
// Self-checking bench for the converter fault-protection block.
// Assumes the design's default parameters and its zero-wait-state APB slave.
`timescale 1ns/1ps
module testbench
    import fault_prot_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic vin_below_cmp = 1'b0, overcurrent_cmp = 1'b0, output_below_cmp = 1'b0;
    logic output_above_cmp = 1'b0, overtemp_cmp = 1'b0, high_pwm = 1'b0, low_pwm = 1'b0;
    logic high_gate_drive, low_gate_drive, irq;
    logic [7:0] input_lockout_level, output_uv_threshold, output_ov_threshold;
    logic [6:0] alert_address;
    logic prog_read_req = 1'b0, prog_write_req = 1'b0, prog_read_allow, prog_write_allow;
    logic [31:0] seed = 32'hcdd3836e;
    logic [31:0] rv;
    logic [33:0] expq[$];
    logic [33:0] ex;
    int failures = 0;
    int cmp_count = 0;
    int bl;

    always #2 clk = ~clk;

    converter_fault_protection u_converter_fault_protection (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .vin_below_cmp(vin_below_cmp), .overcurrent_cmp(overcurrent_cmp),
        .output_below_cmp(output_below_cmp), .output_above_cmp(output_above_cmp),
        .overtemp_cmp(overtemp_cmp), .high_pwm(high_pwm), .low_pwm(low_pwm),
        .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
        .input_lockout_level(input_lockout_level), .output_uv_threshold(output_uv_threshold),
        .output_ov_threshold(output_ov_threshold), .alert_address(alert_address),
        .prog_read_req(prog_read_req), .prog_write_req(prog_write_req),
        .prog_read_allow(prog_read_allow), .prog_write_allow(prog_write_allow), .irq(irq)
    );

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task tally_and_finish();
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: pin value %h, expected %h", $time, g, e);
        end
    endtask

    // Reads carry their expected data in the write-data lane, which the slave ignores
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        expq.push_back({~w, er, d});
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
        apb(1'b0, a, e, 4'hf, er);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        apb(1'b1, a, d, s, 1'b0);
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Random PWM requests; each gate follows its request one cycle later unless gated off
    task pwm_chk(input logic eh, input logic el);
        logic [31:0] r;
        repeat (8) begin
            r = xs();
            @(posedge clk);
            high_pwm <= r[0];
            low_pwm <= r[1];
            settle(1);
            chk(32'(high_gate_drive), 32'(r[0] & eh));
            chk(32'(low_gate_drive), 32'(r[1] & el));
        end
    endtask

    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            cmp_count++;
            if (expq.size() == 0) begin
                failures++;
                $display("mismatch at %0t: unexpected transfer", $time);
            end else begin
                ex = expq.pop_front();
                if (pslverr !== ex[32] || (ex[33] && prdata !== ex[31:0])) begin
                    failures++;
                    $display("mismatch at %0t: read %h err %b, expected %h err %b",
                             $time, prdata, pslverr, ex[31:0], ex[32]);
                end
            end
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle(4);
        rd(OFS_INPUT_LOCKOUT_LEVEL, {24'h0, LOCKOUT_LEVEL_RST});
        rd(OFS_OUTPUT_UV_THRESHOLD, {24'h0, UV_THRESHOLD_RST});
        rd(OFS_OUTPUT_OV_THRESHOLD, {24'h0, OV_THRESHOLD_RST});
        rd(OFS_ALERT_ADDRESS, {25'h0, ALERT_ADDRESS_RST});
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
        rd(8'h30, 32'h0, 1'b1);
        apb(1'b1, 8'h30, 32'hffff_ffff, 4'hf, 1'b1);
        rv = xs();
        wr(OFS_ALERT_ADDRESS, rv);
        rd(OFS_ALERT_ADDRESS, rv & 32'h7f);
        wr(OFS_ALERT_ADDRESS, ~rv, 4'he);
        rd(OFS_ALERT_ADDRESS, rv & 32'h7f);
        wr(OFS_OUTPUT_OV_THRESHOLD, rv >> 8);
        wr(OFS_INPUT_LOCKOUT_LEVEL, rv >> 16);
        wr(OFS_OUTPUT_UV_THRESHOLD, rv >> 24);
        rd(OFS_INPUT_LOCKOUT_LEVEL, (rv >> 16) & 32'hff);
        settle(1);
        chk(32'(alert_address), rv & 32'h7f);
        chk(32'(output_ov_threshold), (rv >> 8) & 32'hff);
        chk(32'(input_lockout_level), (rv >> 16) & 32'hff);
        chk(32'(output_uv_threshold), rv >> 24);
        pwm_chk(1'b1, 1'b1);
        wr(OFS_ANALOG_TEST_CONTROL, 32'h1 << DRV_DIS_BIT);
        pwm_chk(1'b0, 1'b0);
        wr(OFS_ANALOG_TEST_CONTROL, 32'h1 << HI_DIS_BIT);
        rd(OFS_ANALOG_TEST_CONTROL, 32'h1 << HI_DIS_BIT);
        pwm_chk(1'b0, 1'b1);
        wr(OFS_ANALOG_TEST_CONTROL, 32'h1 << LO_DIS_BIT);
        pwm_chk(1'b1, 1'b0);
        wr(OFS_ANALOG_TEST_CONTROL, 32'h0);
        pwm_chk(1'b1, 1'b1);
        @(posedge clk);
        vin_below_cmp <= 1'b1;
        settle(8);
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << FLAG_VIN);
        settle(1);
        chk(32'(irq), 32'h0);
        // Firmware's part while the input is low: both sides held off
        wr(OFS_ANALOG_TEST_CONTROL, (32'h1 << HI_DIS_BIT) | (32'h1 << LO_DIS_BIT));
        pwm_chk(1'b0, 1'b0);
        wr(OFS_ANALOG_TEST_CONTROL, 32'h0);
        vin_below_cmp <= 1'b0;
        settle(8);
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
        for (int k = 0; k < 2; k++) begin
            bl = (k == 0) ? FLAG_OUV : FLAG_OOV;
            {output_above_cmp, output_below_cmp} <= 2'(1 << k);
            settle(8);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
            wr(OFS_ANALOG_BLOCK_ENABLES, 32'h1 << k);
            settle(8);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << bl);
            pwm_chk(1'b1, 1'b1);
            wr(OFS_PROTECTION_ENABLES, 32'h1 << k);
            rd(OFS_PROTECTION_ENABLES, 32'h1 << k);
            pwm_chk(1'b0, 1'b0);
            // A clear that beat the live set would let the gate out for one cycle
            @(posedge clk);
            high_pwm <= 1'b1;
            wr(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << bl);
            settle(1);
            chk(32'(high_gate_drive), 32'h0);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << bl);
            {output_above_cmp, output_below_cmp} <= 2'h0;
            settle(8);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << bl);
            pwm_chk(1'b0, 1'b0);
            wr(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << bl);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
            pwm_chk(1'b1, 1'b1);
            wr(OFS_ANALOG_BLOCK_ENABLES, 32'h0);
            wr(OFS_PROTECTION_ENABLES, 32'h0);
        end
        overtemp_cmp <= 1'b1;
        settle(8);
        pwm_chk(1'b0, 1'b0);
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << FLAG_OT);
        settle(1);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_MASK, 32'h1 << FLAG_OT);
        settle(1);
        chk(32'(irq), 32'h0);
        wr(OFS_INTERRUPT_CONTROL, 32'h1 << GIE_BIT);
        rd(OFS_INTERRUPT_CONTROL, 32'h1 << GIE_BIT);
        settle(1);
        chk(32'(irq), 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        settle(1);
        chk(32'(irq), 32'h0);
        wr(OFS_IRQ_MASK, 32'h1 << FLAG_OT);
        rd(OFS_IRQ_MASK, 32'h1 << FLAG_OT);
        overtemp_cmp <= 1'b0;
        settle(8);
        pwm_chk(1'b1, 1'b1);
        chk(32'(irq), 32'h1);
        wr(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << FLAG_OT);
        settle(1);
        chk(32'(irq), 32'h0);
        // Overcurrent: comparator held high throughout, so only gating decides
        @(posedge clk);
        high_pwm <= 1'b0;
        overcurrent_cmp <= 1'b1;
        wr(OFS_OVERCURRENT_CONTROL, 32'h0);
        high_pwm <= 1'b1;
        settle(60);
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
        high_pwm <= 1'b0;
        wr(OFS_OVERCURRENT_CONTROL, 32'h1 << OC_EN_BIT);
        settle(60);
        rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
        for (int s = 0; s < 4; s++) begin
            case (s)
                0: bl = int'(BLANK0_CYC);
                1: bl = int'(BLANK1_CYC);
                2: bl = int'(BLANK2_CYC);
                default: bl = int'(BLANK3_CYC);
            endcase
            wr(OFS_OVERCURRENT_CONTROL, (32'(s) << OC_BLANK_LSB) | 32'h1);
            rd(OFS_OVERCURRENT_CONTROL, (32'(s) << OC_BLANK_LSB) | 32'h1);
            high_pwm <= 1'b1;
            // First read samples the last blanked cycle, the second one after it
            settle(bl - 1);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << FLAG_OC);
            high_pwm <= 1'b0;
            wr(OFS_PERIPHERAL_FLAGS_TWO, 32'h1 << FLAG_OC);
            rd(OFS_PERIPHERAL_FLAGS_TWO, 32'h0);
        end
        prog_read_req <= 1'b1;
        prog_write_req <= 1'b1;
        settle(1);
        chk(32'({prog_read_allow, prog_write_allow}), 32'h3);
        wr(OFS_CODE_PROTECT, 32'h1 << CP_BIT);
        settle(1);
        chk(32'({prog_read_allow, prog_write_allow}), 32'h0);
        wr(OFS_CODE_PROTECT, 32'h0);
        rd(OFS_CODE_PROTECT, 32'h1 << CP_BIT);
        settle(1);
        chk(32'({prog_read_allow, prog_write_allow}), 32'h0);
        settle(2);
        tally_and_finish();
    end
endmodule
